// ===== rtl/jlcr_pkg.sv
/*
  Shared constants for the serial link configuration registers: device
  register addresses, reset values, field positions, sync source codes and
  the controller's own AHB-Lite register map.
  Assumes nothing of its surroundings; both ends and the bench use it.
*/
`default_nettype none
package jlcr_pkg;
  // Device register addresses on the configuration port
  localparam logic [11:0] ADDR_MODE   = 12'h201;
  localparam logic [11:0] ADDR_KM1    = 12'h202;
  localparam logic [11:0] ADDR_SYNC_N = 12'h203;
  localparam logic [11:0] ADDR_CTRL   = 12'h204;
  localparam logic [11:0] ADDR_TEST   = 12'h205;
  // Reset values
  localparam logic [7:0] RST_MODE   = 8'h02;
  localparam logic [7:0] RST_KM1    = 8'h1F;
  localparam logic [7:0] RST_SYNC_N = 8'h01;
  localparam logic [7:0] RST_CTRL   = 8'h03;
  localparam logic [7:0] RST_TEST   = 8'h00;
  // Link control and sync request field positions
  localparam int CTRL_SCR_BIT   = 0;
  localparam int CTRL_FMT_BIT   = 1;
  localparam int CTRL_SRC_LO    = 2;
  localparam int CTRL_LANES_BIT = 4;
  localparam int SYNC_N_BIT     = 0;
  // Sync source codes
  localparam logic [1:0] SRC_SE_PIN = 2'h0;
  localparam logic [1:0] SRC_TS_PIN = 2'h1;
  localparam logic [1:0] SRC_NONE   = 2'h2;
  // Synchroniser reset levels: receiver enable off, sync pins idle high
  localparam logic [2:0] SYNC_IDLE  = 3'h3;
  // Lane groups
  localparam logic [7:0] LANES_LOWER = 8'h0F;
  localparam logic [7:0] LANES_UPPER = 8'hF0;
  // Frames per multiframe in 64b/66b modes is this times E over F
  localparam int K_66B_SCALE = 256;
  // Controller registers (byte offsets on AHB-Lite)
  localparam logic [7:0] HOFS_ADDR   = 8'h00;
  localparam logic [7:0] HOFS_WDATA  = 8'h04;
  localparam logic [7:0] HOFS_CMD    = 8'h08;
  localparam logic [7:0] HOFS_STATUS = 8'h0C;
  localparam logic [7:0] HOFS_ENABLE = 8'h10;
  // Command, status and enable bits
  localparam int CMD_GO_BIT      = 0;
  localparam int CMD_WRITE_BIT   = 1;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_DONE_BIT   = 1;
  localparam int STAT_REFUSE_BIT = 2;
  localparam int STAT_RDATA_LO   = 8;
  localparam int EN_LINK_BIT     = 0;
  localparam int EN_CAL_BIT      = 1;
endpackage
`default_nettype wire

// ===== rtl/jlcr_if.sv
/*
  Configuration port between the link controller and the converter's link
  registers, plus the enables the controller owns.
  Assumes both ends share one clock; a request is held until acknowledged.
*/
`timescale 1ns/1ps
`default_nettype none
interface jlcr_if;
  logic        cfg_req;            // Request held until ack
  logic        cfg_write;          // 1 write, 0 read
  logic [11:0] cfg_addr;           // Register address
  logic [7:0]  cfg_wdata;          // Write data
  logic [7:0]  cfg_rdata;          // Read data, valid with ack
  logic        cfg_ack;            // One-cycle completion pulse
  logic        serial_link_enable; // Link enable from controller
  logic        calibration_enable; // Calibration enable from controller

  modport dev (input cfg_req, cfg_write, cfg_addr, cfg_wdata, serial_link_enable,
               calibration_enable, output cfg_rdata, cfg_ack);
  modport ctl (output cfg_req, cfg_write, cfg_addr, cfg_wdata, serial_link_enable,
               calibration_enable, input cfg_rdata, cfg_ack);
endinterface
`default_nettype wire

// ===== rtl/jlcr_device.sv
/*
  Converter-side link configuration registers and the link controls they
  steer: mode, multiframe length, software sync, lane map, sync source,
  sample format, scrambler and test pattern selection.
  Assumes a mode table outside that describes the selected mode (its
  64b/66b flag, E and F) on this clock, a permit mask from the mode lock
  on this clock, and sync pins that arrive asynchronously, active low.
  Assumes the controller holds each request until the one-cycle ack and
  keeps one request outstanding; protected writes are refused there, so
  this end stores whatever reaches it apart from unpermitted modes.
  Every output is registered; all but link_mode_select, which is the mode register itself, lag their setting by one clock.
*/
// Register access over AHB-Lite was left to the implementer.
// Contract
// - Eight-bit link mode field, resets to 0x02
// - Change mode only with link, calibration off
// - Only mode-lock permitted modes are accepted
// - Multiframe field holds frames minus one, 0x1F
// - 64b/66b modes use 256*E/F frames instead
// - Change other fields only with link off
// - Sync request bit resets 1; 0 requests
// - Software request acts with any source
// - Stuck-low selected pin holds request asserted
// - Lane bit picks lower or upper four lanes
// - Upper lanes only for modes up to eight; any mode may select them here
// - Source 0 pin, 1 timestamp, 2 none
// - Format bit: 0 offset binary, 1 twos
// - Scrambler bit enables 8b/10b scrambling
// - 64b/66b modes always scramble
// - Link disabled holds logic reset, lanes down
`timescale 1ns/1ps
`default_nettype none
module jlcr_device (
  input  wire logic         clk_sys,                  // 40 MHz system clock
  input  wire logic         rst,                      // Async reset, active high
  jlcr_if.dev               cfg,                      // Configuration port
  input  wire logic [255:0] mode_permitted,           // Mode-lock permit mask
  input  wire logic         mode_is_64b66b,           // Selected mode codes 64b/66b
  input  wire logic [3:0]   mode_e,                   // Selected mode E parameter
  input  wire logic [4:0]   mode_f,                   // Selected mode F parameter
  input  wire logic         single_ended_sync_pin,    // Sync pin, active low
  input  wire logic         timestamp_pin,            // Timestamp pin, active low
  input  wire logic         timestamp_receiver_enable,// Timestamp receiver on
  output var  logic [7:0]   link_mode_select,         // Current mode
  output var  logic [11:0]  frames_per_multiframe,    // Effective K
  output var  logic         link_sync_request,        // Sync request, active high
  output var  logic [7:0]   lane_power_up,            // Per-lane power, each link
  output var  logic         sample_format_select,     // 1 twos complement
  output var  logic         scrambler_active,         // Scrambler in use
  output var  logic [4:0]   link_test_control,        // Test pattern select
  output var  logic         link_logic_reset,         // Link logic held in reset
  output var  logic         link_clock_enable,        // Link clock gate
  output var  logic         multiframe_counter_reset  // Multiframe counter reset
);
  logic [7:0] frames_per_multiframe_minus_one;
  logic [7:0] software_sync_request;
  logic [7:0] link_control;
  logic [7:0] test_reg;
  logic [2:0] pin_raw;
  wire  [2:0] pin_sync;
  logic [4:0] addr_sel;
  logic       pin_low;
  logic       next_sync_req;
  logic [11:0] next_k;
  logic [11:0] k_66b;

  // Address decode shared by the write and read paths, one bit per register,
  // so the two can never disagree on the map; other addresses select nothing
  function automatic logic [4:0] reg_select(input logic [11:0] addr);
    logic [4:0] sel;
    sel = 5'h00;
    if (addr == jlcr_pkg::ADDR_MODE) begin
      sel = 5'h01;
    end else if (addr == jlcr_pkg::ADDR_KM1) begin
      sel = 5'h02;
    end else if (addr == jlcr_pkg::ADDR_SYNC_N) begin
      sel = 5'h04;
    end else if (addr == jlcr_pkg::ADDR_CTRL) begin
      sel = 5'h08;
    end else if (addr == jlcr_pkg::ADDR_TEST) begin
      sel = 5'h10;
    end
    return sel;
  endfunction
  assign addr_sel = reg_select(cfg.cfg_addr);

  // Register writes; mode writes outside the permit mask are dropped
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      link_mode_select                <= jlcr_pkg::RST_MODE;
      frames_per_multiframe_minus_one <= jlcr_pkg::RST_KM1;
      software_sync_request           <= jlcr_pkg::RST_SYNC_N;
      link_control                    <= jlcr_pkg::RST_CTRL;
      test_reg                        <= jlcr_pkg::RST_TEST;
    end else if (cfg.cfg_req && cfg.cfg_write && !cfg.cfg_ack) begin
      if (addr_sel[0]) begin
        if (mode_permitted[cfg.cfg_wdata]) begin
          link_mode_select <= cfg.cfg_wdata;
        end
      end else if (addr_sel[1]) begin
        frames_per_multiframe_minus_one <= cfg.cfg_wdata;
      end else if (addr_sel[2]) begin
        software_sync_request <= cfg.cfg_wdata;
      end else if (addr_sel[3]) begin
        link_control <= cfg.cfg_wdata;
      end else if (addr_sel[4]) begin
        test_reg <= cfg.cfg_wdata;
      end
    end
  end

  // Answer every request one cycle after it is seen; unmapped reads give zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg.cfg_ack   <= 1'b0;
      cfg.cfg_rdata <= 8'h00;
    end else begin
      cfg.cfg_ack <= cfg.cfg_req && !cfg.cfg_ack;
      if (addr_sel[0]) begin
        cfg.cfg_rdata <= link_mode_select;
      end else if (addr_sel[1]) begin
        cfg.cfg_rdata <= frames_per_multiframe_minus_one;
      end else if (addr_sel[2]) begin
        cfg.cfg_rdata <= software_sync_request;
      end else if (addr_sel[3]) begin
        cfg.cfg_rdata <= link_control;
      end else if (addr_sel[4]) begin
        cfg.cfg_rdata <= test_reg;
      end else begin
        cfg.cfg_rdata <= 8'h00;
      end
    end
  end

  // Two-stage synchronisers, one per pin and one for the receiver enable; only the second stage feeds logic.
  // Reset leaves the pins idle high and the receiver off, so no false request
  assign pin_raw = {timestamp_receiver_enable, timestamp_pin, single_ended_sync_pin};
  for (genvar i = 0; i < 3; i++) begin : g_sync
    logic [1:0] stage;
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        stage <= {2{jlcr_pkg::SYNC_IDLE[i]}};
      end else begin
        stage <= {stage[0], pin_raw[i]};
      end
    end
    assign pin_sync[i] = stage[1];
  end

  // Selected pin low; the timestamp pin only counts with its receiver on
  always_comb begin
    pin_low = 1'b0;
    case (link_control[jlcr_pkg::CTRL_SRC_LO +: 2])
      jlcr_pkg::SRC_SE_PIN: pin_low = !pin_sync[0];
      jlcr_pkg::SRC_TS_PIN: pin_low = pin_sync[2] && !pin_sync[1];
      default:              pin_low = 1'b0;
    endcase
    // A stuck-low pin keeps the request up until the source is changed or, for the timestamp pin, its receiver is turned off
    next_sync_req = !software_sync_request[jlcr_pkg::SYNC_N_BIT]
                    || pin_low;
  end

  // Effective frames per multiframe; F of zero cannot occur in a real mode
  always_comb begin
    k_66b = 12'h000;
    if (mode_f != 5'h00) begin
      k_66b = 12'(jlcr_pkg::K_66B_SCALE * int'(mode_e) / int'(mode_f));
    end
    if (mode_is_64b66b) begin
      next_k = k_66b;
    end else begin
      next_k = {4'h0, frames_per_multiframe_minus_one} + 12'h001;
    end
  end

  // Link-side controls, all registered; disabled link is held quiet
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      frames_per_multiframe    <= 12'h020;
      link_sync_request        <= 1'b0;
      lane_power_up            <= 8'h00;
      sample_format_select     <= 1'b1;
      scrambler_active         <= 1'b1;
      link_test_control        <= 5'h00;
      link_logic_reset         <= 1'b1;
      link_clock_enable        <= 1'b0;
      multiframe_counter_reset <= 1'b1;
    end else begin
      frames_per_multiframe    <= next_k;
      link_sync_request        <= next_sync_req;
      sample_format_select     <= link_control[jlcr_pkg::CTRL_FMT_BIT];
      scrambler_active         <= mode_is_64b66b
                                  || link_control[jlcr_pkg::CTRL_SCR_BIT];
      link_test_control        <= test_reg[4:0];
      link_logic_reset         <= !cfg.serial_link_enable;
      link_clock_enable        <= cfg.serial_link_enable;
      multiframe_counter_reset <= !cfg.serial_link_enable;
      if (!cfg.serial_link_enable) begin
        lane_power_up <= 8'h00;
      end else if (link_control[jlcr_pkg::CTRL_LANES_BIT]) begin
        lane_power_up <= jlcr_pkg::LANES_UPPER;
      end else begin
        lane_power_up <= jlcr_pkg::LANES_LOWER;
      end
    end
  end
endmodule // jlcr_device
`default_nettype wire

// ===== rtl/jlcr_controller.sv
/*
  Host-side link controller: an AHB-Lite slave whose registers let software
  issue single reads and writes to the converter's link registers and own
  the link and calibration enables. Writes that would change settings while
  the link is on, or the mode while calibration is on, are refused and flagged.
  Assumes one AHB-Lite master and zero-wait single word transfers.
*/
`timescale 1ns/1ps
`default_nettype none
module jlcr_controller (
  input  wire logic        clk_sys,   // 40 MHz system clock
  input  wire logic        rst,       // Async reset, active high
  input  wire logic        hsel,      // Slave select
  input  wire logic [31:0] haddr,     // Byte address
  input  wire logic [1:0]  htrans,    // Transfer type
  input  wire logic        hwrite,    // Write transfer
  input  wire logic [2:0]  hsize,     // Transfer size, word only
  input  wire logic [31:0] hwdata,    // Write data
  input  wire logic        hready,    // Bus ready
  output var  logic [31:0] hrdata,    // Read data
  output var  logic        hreadyout, // Always ready
  output var  logic        hresp,     // Always OKAY
  jlcr_if.ctl              cfg        // Port to the converter
);
  logic [11:0] dev_addr;
  logic [7:0]  dev_wdata;
  logic [7:0]  dev_rdata;
  logic        cmd_write;
  logic        busy;
  logic        done;
  logic        refused;
  logic        wr_pend;
  logic [7:0]  wr_ofs;
  logic        go;
  logic        blocked;
  logic [31:0] status_word;

  // Address phase capture; every register is a whole word
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_ofs  <= 8'h00;
    end else if (hready) begin
      wr_pend <= hsel && htrans[1] && hwrite;
      wr_ofs  <= haddr[7:0];
    end
  end

  assign go = wr_pend && (wr_ofs == jlcr_pkg::HOFS_CMD)
              && hwdata[jlcr_pkg::CMD_GO_BIT] && !busy;
  // Protected writes: mode needs link and calibration off, the rest link off
  assign blocked = hwdata[jlcr_pkg::CMD_WRITE_BIT] && (cfg.serial_link_enable
                   || (dev_addr == jlcr_pkg::ADDR_MODE && cfg.calibration_enable));
  assign status_word = {16'h0000, dev_rdata, 5'h00, refused, done, busy};

  // Read data registered at the address phase so it stands in the data phase
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      if (haddr[7:0] == jlcr_pkg::HOFS_ADDR) begin
        hrdata <= {20'h00000, dev_addr};
      end else if (haddr[7:0] == jlcr_pkg::HOFS_WDATA) begin
        hrdata <= {24'h000000, dev_wdata};
      end else if (haddr[7:0] == jlcr_pkg::HOFS_STATUS) begin
        hrdata <= status_word;
      end else if (haddr[7:0] == jlcr_pkg::HOFS_ENABLE) begin
        hrdata <= {30'h0, cfg.calibration_enable, cfg.serial_link_enable};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // Zero-wait, always OKAY
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Software-held settings
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dev_addr               <= jlcr_pkg::ADDR_MODE;
      dev_wdata              <= 8'h00;
      cfg.serial_link_enable <= 1'b0;
      cfg.calibration_enable <= 1'b0;
    end else if (wr_pend) begin
      if (wr_ofs == jlcr_pkg::HOFS_ADDR && !busy) begin
        dev_addr <= hwdata[11:0];
      end else if (wr_ofs == jlcr_pkg::HOFS_WDATA && !busy) begin
        dev_wdata <= hwdata[7:0];
      end else if (wr_ofs == jlcr_pkg::HOFS_ENABLE) begin
        cfg.serial_link_enable <= hwdata[jlcr_pkg::EN_LINK_BIT];
        cfg.calibration_enable <= hwdata[jlcr_pkg::EN_CAL_BIT];
      end
    end
  end

  // Transfer sequencing; a new event wins over a clear in the same cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy          <= 1'b0;
      done          <= 1'b0;
      refused       <= 1'b0;
      cmd_write     <= 1'b0;
      dev_rdata     <= 8'h00;
      cfg.cfg_req   <= 1'b0;
      cfg.cfg_write <= 1'b0;
      cfg.cfg_addr  <= 12'h000;
      cfg.cfg_wdata <= 8'h00;
    end else begin
      if (wr_pend && wr_ofs == jlcr_pkg::HOFS_STATUS) begin
        if (hwdata[jlcr_pkg::STAT_DONE_BIT]) done <= 1'b0;
        if (hwdata[jlcr_pkg::STAT_REFUSE_BIT]) refused <= 1'b0;
      end
      if (go && blocked) begin
        refused <= 1'b1;
      end else if (go) begin
        busy          <= 1'b1;
        cmd_write     <= hwdata[jlcr_pkg::CMD_WRITE_BIT];
        cfg.cfg_req   <= 1'b1;
        cfg.cfg_write <= hwdata[jlcr_pkg::CMD_WRITE_BIT];
        cfg.cfg_addr  <= dev_addr;
        cfg.cfg_wdata <= dev_wdata;
      end else if (busy && cfg.cfg_ack) begin
        busy        <= 1'b0;
        done        <= 1'b1;
        cfg.cfg_req <= 1'b0;
        if (!cmd_write) dev_rdata <= cfg.cfg_rdata;
      end
    end
  end
endmodule // jlcr_controller
`default_nettype wire

// ===== verification/jlcr_properties.sv
/*
  Checker for the configuration port between link controller and device.
  Assumes it is instantiated beside the interface, one clock, reset async high.
*/
`timescale 1ns/1ps
`default_nettype none
module jlcr_properties (
  input wire logic       clk_sys,            // System clock
  input wire logic       rst,                // Async reset, active high
  input wire logic       cfg_req,            // Request level
  input wire logic       cfg_write,          // Write when high
  input wire logic [11:0] cfg_addr,          // Register address
  input wire logic [7:0] cfg_wdata,          // Write data
  input wire logic [7:0] cfg_rdata,          // Read data
  input wire logic       cfg_ack,            // Completion pulse
  input wire logic       serial_link_enable, // Link enable
  input wire logic       calibration_enable  // Calibration enable
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  logic [7:0] last_test;

  // Mirror of the test register, so a read can be held against the last accepted write
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      last_test <= jlcr_pkg::RST_TEST;
    end else if (cfg_ack && cfg_write && cfg_addr == jlcr_pkg::ADDR_TEST) begin
      last_test <= cfg_wdata;
    end
  end

  // A transfer is one request rise, one ack cycle, then both low
  sequence s_req_start;
    $rose(cfg_req);
  endsequence
  sequence s_answer;
    cfg_ack ##1 (!cfg_ack && !cfg_req);
  endsequence

  chk_req_answered: assert property (s_req_start |=> s_answer)
    else $error("request not answered within one cycle");
  chk_ack_with_req: assert property (cfg_ack |-> cfg_req)
    else $error("ack without request");
  chk_req_stable: assert property (cfg_req && !cfg_ack |=>
      cfg_req && $stable(cfg_addr) && $stable(cfg_write) && $stable(cfg_wdata))
    else $error("request changed before ack");
  chk_no_write_live: assert property (cfg_req && cfg_write |-> !serial_link_enable)
    else $error("write issued while link enabled");
  chk_mode_cal_off: assert property (cfg_req && cfg_write && cfg_addr == jlcr_pkg::ADDR_MODE
      |-> !calibration_enable)
    else $error("mode write issued while calibration enabled");
  chk_unmapped_zero: assert property (cfg_ack && !cfg_write
      && (cfg_addr < jlcr_pkg::ADDR_MODE || cfg_addr > jlcr_pkg::ADDR_TEST) |-> cfg_rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_test_readback: assert property (cfg_ack && !cfg_write && cfg_addr == jlcr_pkg::ADDR_TEST
      |-> cfg_rdata == last_test)
    else $error("test register read differs from last write");
  chk_ack_single: assert property (cfg_ack |=> (!cfg_ack) [*2])
    else $error("ack longer than one cycle");
endmodule // jlcr_properties
`default_nettype wire

// ===== verification/tb_jesd204c_link_config_regs.sv
/*
  Bench for controller and device joined by the configuration interface;
  software accesses go over AHB-Lite. Assumes a 40 MHz clock, async reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_jesd204c_link_config_regs;
  logic        clk_sys, rst, hsel, hwrite, hreadyout, hresp, mode_is_64b66b;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [255:0] mode_permitted;
  logic [3:0]  mode_e;
  logic [4:0]  mode_f, test_out;
  logic        se_pin, ts_pin, ts_en, sync_req, fmt, scrambler_enable, lrst, lclk, mfrst;
  logic [7:0]  mode_out, lanes;
  logic [11:0] frames;
  int          n_errors, num_checks;
  logic [7:0]  rst_vals [5] = '{jlcr_pkg::RST_MODE, jlcr_pkg::RST_KM1, jlcr_pkg::RST_SYNC_N,
                                jlcr_pkg::RST_CTRL, jlcr_pkg::RST_TEST};

  jlcr_if bus ();
  jlcr_controller jlcr_controller_i (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cfg(bus));
  jlcr_device jlcr_device_i (.clk_sys(clk_sys), .rst(rst), .cfg(bus),
    .mode_permitted(mode_permitted), .mode_is_64b66b(mode_is_64b66b), .mode_e(mode_e),
    .mode_f(mode_f), .single_ended_sync_pin(se_pin), .timestamp_pin(ts_pin),
    .timestamp_receiver_enable(ts_en), .link_mode_select(mode_out),
    .frames_per_multiframe(frames), .link_sync_request(sync_req), .lane_power_up(lanes),
    .sample_format_select(fmt), .scrambler_active(scrambler_enable), .link_test_control(test_out),
    .link_logic_reset(lrst), .link_clock_enable(lclk), .multiframe_counter_reset(mfrst));
  jlcr_properties jlcr_properties_i (.clk_sys(clk_sys), .rst(rst), .cfg_req(bus.cfg_req),
    .cfg_write(bus.cfg_write), .cfg_addr(bus.cfg_addr), .cfg_wdata(bus.cfg_wdata),
    .cfg_rdata(bus.cfg_rdata), .cfg_ack(bus.cfg_ack),
    .serial_link_enable(bus.serial_link_enable), .calibration_enable(bus.calibration_enable));

  task automatic tally_and_finish();
    if (n_errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Bounded wait for hready; a stuck bus ends the run rather than hanging
  task automatic wait_ready();
    int i;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (hreadyout !== 1'b1 && i < 20);
    if (hreadyout !== 1'b1) begin
      n_errors++;
      tally_and_finish();
    end
  endtask

  // One single-word AHB-Lite transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    check(hresp, 1'b0);
  endtask

  // One device access through the controller: address, data, go, poll, clear
  task automatic dev(input logic wr, input logic [11:0] a, input logic [7:0] d,
                     output logic [7:0] rd, output logic rf);
    logic [31:0] s;
    int i;
    ahb(1'b1, jlcr_pkg::HOFS_ADDR, {20'h0, a}, s);
    ahb(1'b1, jlcr_pkg::HOFS_WDATA, {24'h0, d}, s);
    ahb(1'b1, jlcr_pkg::HOFS_CMD, {30'h0, wr, 1'b1}, s);
    s = 32'h0;
    i = 0;
    while (s[2:1] === 2'h0 && i < 20) begin
      ahb(1'b0, jlcr_pkg::HOFS_STATUS, 32'h0, s);
      i++;
    end
    if (s[2:1] === 2'h0) begin
      n_errors++;
      tally_and_finish();
    end
    rd = s[15:8];
    rf = s[jlcr_pkg::STAT_REFUSE_BIT];
    ahb(1'b1, jlcr_pkg::HOFS_STATUS, 32'h6, s);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic exp_rf);
    logic [7:0] rd;
    logic rf;
    dev(1'b1, a, d, rd, rf);
    check(rf, exp_rf);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] rd;
    logic rf;
    dev(1'b0, a, 8'h00, rd, rf);
    check(rd, exp);
  endtask

  task automatic en(input logic [1:0] v);
    ahb(1'b1, jlcr_pkg::HOFS_ENABLE, {30'h0, v}, r);
    repeat (6) @(posedge clk_sys);
  endtask

  // Clock source
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    mode_permitted = {256{1'b1}};
    mode_is_64b66b = 1'b0;
    mode_e = 4'h2;
    mode_f = 5'h04;
    se_pin = 1'b1;
    ts_pin = 1'b1;
    ts_en = 1'b0;
    n_errors = 0;
    num_checks = 0;
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    check(mode_out, jlcr_pkg::RST_MODE);
    check(frames, 12'h020);
    check({sync_req, lanes, fmt, scrambler_enable}, 11'h003);
    check({lrst, lclk, mfrst}, 3'b101);
    for (int k = 0; k < 5; k++) rdc(jlcr_pkg::ADDR_MODE + 12'(k), rst_vals[k]);
    wr(jlcr_pkg::ADDR_CTRL, 8'hE3, 1'b0);
    rdc(jlcr_pkg::ADDR_CTRL, 8'hE3);
    check({fmt, scrambler_enable}, 2'b11);
    wr(jlcr_pkg::ADDR_CTRL, 8'h00, 1'b0);
    check({fmt, scrambler_enable}, 2'b00);
    mode_is_64b66b <= 1'b1;
    wr(jlcr_pkg::ADDR_KM1, 8'h0F, 1'b0);
    check(frames, 12'(jlcr_pkg::K_66B_SCALE * 2 / 4));
    check(scrambler_enable, 1'b1);
    mode_is_64b66b <= 1'b0;
    en(2'h0);
    check(frames, 12'h010);
    mode_permitted <= 256'h24;
    wr(jlcr_pkg::ADDR_MODE, 8'h05, 1'b0);
    wr(jlcr_pkg::ADDR_MODE, 8'h07, 1'b0);
    rdc(jlcr_pkg::ADDR_MODE, 8'h05);
    check(mode_out, 8'h05);
    wr(jlcr_pkg::ADDR_SYNC_N, 8'h00, 1'b0);
    for (int s = 0; s < 4; s++) begin
      wr(jlcr_pkg::ADDR_CTRL, {4'h0, 2'(s), 2'h0}, 1'b0);
      check(sync_req, 1'b1);
    end
    wr(jlcr_pkg::ADDR_SYNC_N, 8'hFF, 1'b0);
    se_pin <= 1'b0;
    ts_pin <= 1'b0;
    ts_en <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      wr(jlcr_pkg::ADDR_CTRL, {4'h0, 2'(s), 2'h0}, 1'b0);
      check(sync_req, 1'(s < 2));
    end
    ts_en <= 1'b0;
    wr(jlcr_pkg::ADDR_CTRL, 8'h04, 1'b0);
    check(sync_req, 1'b0);
    se_pin <= 1'b1;
    ts_pin <= 1'b1;
    wr(jlcr_pkg::ADDR_CTRL, 8'h10, 1'b0);
    en(2'h1);
    check(lanes, 8'hF0);
    check({lrst, lclk, mfrst}, 3'b010);
    wr(jlcr_pkg::ADDR_CTRL, 8'h00, 1'b1);
    wr(jlcr_pkg::ADDR_TEST, 8'h11, 1'b1);
    rdc(jlcr_pkg::ADDR_CTRL, 8'h10);
    en(2'h0);
    check(lanes, 8'h00);
    wr(jlcr_pkg::ADDR_CTRL, 8'h00, 1'b0);
    en(2'h1);
    check(lanes, 8'h0F);
    en(2'h2);
    wr(jlcr_pkg::ADDR_MODE, 8'h02, 1'b1);
    wr(jlcr_pkg::ADDR_TEST, 8'h11, 1'b0);
    check(test_out, 5'h11);
    en(2'h0);
    wr(jlcr_pkg::ADDR_MODE, 8'h02, 1'b0);
    check(mode_out, 8'h02);
    rdc(12'h206, 8'h00);
    ahb(1'b0, 8'h14, 32'h0, r);
    check(r[11:0], 12'h000);
    // Mid-run reset puts the written fields back to their defaults
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    check(test_out, 5'h00);
    rdc(jlcr_pkg::ADDR_KM1, jlcr_pkg::RST_KM1);
    rdc(jlcr_pkg::ADDR_SYNC_N, jlcr_pkg::RST_SYNC_N);
    tally_and_finish();
  end
endmodule // tb_jesd204c_link_config_regs
`default_nettype wire
